// file: lpoc_defs.svh
`ifndef LPOC_DEFS_SVH
`define LPOC_DEFS_SVH
// Memory window layout, byte offsets inside the 4096-byte window
`define LPOC_WIN_AW 12
`define LPOC_DEBUG_HALF_BIT 11
`define LPOC_GROUP_BYTES 128
`define LPOC_VENDOR_BASE 12'h800
`define LPOC_DIRECT_BASE 12'h880
`define LPOC_PKTCTL_SET_OFS 12'h800
`define LPOC_PKTCTL_CLR_OFS 12'h804
// Packet handling option fields
`define LPOC_EXT_TICK_BIT 23
`define LPOC_PHY_VERIFY_BIT 9
`define LPOC_RESET_MARKER_BIT 8
`define LPOC_CONCAT_BIT 7
`define LPOC_REMOTE_BIT 4
`define LPOC_PING_BIT 2
`define LPOC_LINKON_GATE_BIT 1
`define LPOC_PHY_APPLY_BIT 0
`define LPOC_PKTCTL_RESET 32'h0000_0114
`define LPOC_PKTCTL_MASK 32'h0080_0397
// Cycle timer
`define LPOC_CLK_PERIOD_NS 25
`define LPOC_TICK_PERIOD_NS 125000
`define LPOC_TICK_CYCLES (`LPOC_TICK_PERIOD_NS / `LPOC_CLK_PERIOD_NS)
`define LPOC_CYCLES_PER_SEC 13'h1F40
// PHY configuration packet fields
`define LPOC_PHY_ID_HI 31
`define LPOC_PHY_ID_LO 30
`define LPOC_PHY_R_BIT 23
`define LPOC_PHY_T_BIT 22
`define LPOC_PHY_GAP_HI 21
`define LPOC_PHY_GAP_LO 16
`endif

// file: lpoc_far_node.sv
`default_nettype none
// Far bus nodes: one-cycle event pulses and PHY packets
// ev: 0 ping, 1 remote access, 2 remote command, 3 bus reset,
// 4 link-on, 5 self-ID done, 6 external 8 kHz, 7 PHY valid
// Cycle master and priority budget upkeep stay with host
module lpoc_far_node (
  input wire logic clk,
  output logic [7:0] ev,
  output logic [31:0] pktData,
  output logic [31:0] pktInv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ev = 8'h00;
    pktData = 32'h0;
    pktInv = 32'hFFFFFFFF;
  end
  task automatic pulse(input int k);
    @(posedge clk);
    #1 ev[k] = 1'b1;
    @(posedge clk);
    #1 ev[k] = 1'b0;
  endtask
  // A bad packet repeats data in place of its inverse
  task automatic phy(input logic [31:0] d, input logic bad);
    @(posedge clk);
    #1 pktData = d;
    pktInv = bad ? d : ~d;
    ev[7] = 1'b1;
    @(posedge clk);
    #1 ev[7] = 1'b0;
    // Released lines do not keep the last value
    pktData = ~d;
    pktInv = d;
  endtask
endmodule
`default_nettype wire

// file: lpoc_packet_options.sv
// How it works
// - Two 128-byte debug groups sit in the upper 2048 bytes of window.
// - Only the first debug group answers, and only while the EEPROM debug-mode bit is set.
// - Bit 23 picks external 8 kHz or internal tick when source active.
// - Bit 9 set: PHY packet inverse quadlet must equal complement of data.
// - Bit 8 set (reset value 1): bus reset makes a marker packet.
// - Bit 7 set: transmit concatenates packets; resets to zero.
// - Bit 4 set (reset 1): auto reply to remote access and command.
// - Bit 2 set (reset 1): ping received makes self-ID transmit.
// - Bit 1 set: traffic waits for link-on; clear: host link-on suffices.
// - Option bits read back, set by writing one, cleared by software.
// - Self-ID header carries 8-bit generation counting bus resets.
// - Self-ID timestamp is low 3 seconds bits with cycle index.
// - Bit 0 set: PHY config packets update root hold, and gap count when T bit set.
`include "lpoc_defs.svh"
`default_nettype none
module lpoc_packet_options #(
  parameter int TICK_CYCLES = `LPOC_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire lpoc_pkg::lpoc_memreq_t memReq,
  output logic [31:0] memRdData,
  output logic memRdValid,
  input wire logic debugModeEnable,
  input wire logic cycleTickSource,
  input wire logic external8kInput,
  output logic [19:0] cycleTimeCounter,
  input wire logic phyPktValid,
  input wire logic [31:0] phyPktData,
  input wire logic [31:0] phyPktInverse,
  output logic phyPktAccept,
  output logic phyPktError,
  output logic [5:0] phyGapCount,
  output logic rootHold,
  input wire logic busResetDetected,
  output logic busResetPktStrobe,
  output logic concatEnable,
  input wire logic remoteAccessRx,
  input wire logic remoteCommandRx,
  output logic remoteReplyTx,
  output logic remoteConfirmTx,
  input wire logic pingRx,
  output logic selfIdTx,
  input wire logic hostLinkOn,
  input wire logic linkOnPktRx,
  output logic linkTrafficEnable,
  input wire logic selfIdDone,
  output lpoc_pkg::lpoc_selfid_hdr_t selfIdHeader
);
  import lpoc_pkg::*;

  // The tick counter is 13 bits wide
  if (TICK_CYCLES < 2 || TICK_CYCLES > 8192)
  begin : gTickCheck
    $error("TICK_CYCLES must lie between 2 and 8192");
  end

  function automatic logic isOfs(input logic [11:0] a, input logic [11:0] o);
    isOfs = (a[11:2] == o[11:2]);
  endfunction

  logic [31:0] pktCtl_q, pktCtl_d;
  logic [12:0] cycIdx_q, cycIdx_d;
  logic [6:0] secIdx_q, secIdx_d;
  logic [12:0] tickCnt_q, tickCnt_d;
  logic extPrev_q, linkOnSeen_q;
  logic [7:0] gen_q;

  // Debug half, then one of the two 128-byte groups
  wire inDebugHalf = memReq.addr[`LPOC_DEBUG_HALF_BIT];
  wire inVendor = inDebugHalf &&
    (memReq.addr < `LPOC_VENDOR_BASE + 12'(`LPOC_GROUP_BYTES));
  wire accessOk = debugModeEnable && inVendor;
  wire setHit = accessOk && memReq.wr &&
    isOfs(memReq.addr, `LPOC_PKTCTL_SET_OFS);
  wire clrHit = accessOk && memReq.wr &&
    isOfs(memReq.addr, `LPOC_PKTCTL_CLR_OFS);
  wire readHit = accessOk && memReq.rd &&
    (isOfs(memReq.addr, `LPOC_PKTCTL_SET_OFS) ||
     isOfs(memReq.addr, `LPOC_PKTCTL_CLR_OFS));
  wire [31:0] laneMask = {{8{memReq.byteEn[3]}}, {8{memReq.byteEn[2]}},
    {8{memReq.byteEn[1]}}, {8{memReq.byteEn[0]}}};
  wire [31:0] wrBits = memReq.wdata & laneMask & `LPOC_PKTCTL_MASK;

  always_comb
  begin
    pktCtl_d = pktCtl_q;
    if (setHit)
      pktCtl_d = pktCtl_d | wrBits;
    if (clrHit)
      pktCtl_d = pktCtl_d & ~wrBits;
  end

  // Cycle timer tick selection
  wire extEdge = external8kInput && !extPrev_q;
  wire intTick = (tickCnt_q == 13'(TICK_CYCLES - 1));
  wire useExt = cycleTickSource && pktCtl_q[`LPOC_EXT_TICK_BIT];
  wire cycTick = useExt ? extEdge : intTick;
  wire lastCyc = (cycIdx_q == `LPOC_CYCLES_PER_SEC - 13'h1);

  always_comb
  begin
    tickCnt_d = intTick ? 13'h0 : tickCnt_q + 13'h1;
    cycIdx_d = cycIdx_q;
    secIdx_d = secIdx_q;
    if (cycTick)
    begin
      cycIdx_d = lastCyc ? 13'h0 : cycIdx_q + 13'h1;
      if (lastCyc)
        secIdx_d = secIdx_q + 7'h1;
    end
  end

  // PHY packet checks
  wire invGood = (phyPktInverse == ~phyPktData);
  wire phyBad = pktCtl_q[`LPOC_PHY_VERIFY_BIT] && !invGood;
  wire isCfg = (phyPktData[`LPOC_PHY_ID_HI:`LPOC_PHY_ID_LO] == 2'h0);
  wire applyCfg = phyPktValid && !phyBad && isCfg &&
    pktCtl_q[`LPOC_PHY_APPLY_BIT];
  wire gateOpen = hostLinkOn &&
    (!pktCtl_q[`LPOC_LINKON_GATE_BIT] || linkOnSeen_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pktCtl_q <= `LPOC_PKTCTL_RESET;
      tickCnt_q <= 13'h0;
      cycIdx_q <= 13'h0;
      secIdx_q <= 7'h0;
      extPrev_q <= 1'b0;
    end
    else
    begin
      pktCtl_q <= pktCtl_d;
      tickCnt_q <= tickCnt_d;
      cycIdx_q <= cycIdx_d;
      secIdx_q <= secIdx_d;
      extPrev_q <= external8kInput;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memRdData <= 32'h0;
      memRdValid <= 1'b0;
      cycleTimeCounter <= 20'h0;
      concatEnable <= 1'b0;
    end
    else
    begin
      memRdValid <= memReq.rd;
      memRdData <= readHit ? pktCtl_q : 32'h0;
      cycleTimeCounter <= {secIdx_q, cycIdx_q};
      concatEnable <= pktCtl_q[`LPOC_CONCAT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phyPktAccept <= 1'b0;
      phyPktError <= 1'b0;
      phyGapCount <= 6'h3F;
      rootHold <= 1'b0;
    end
    else
    begin
      phyPktAccept <= phyPktValid && !phyBad;
      phyPktError <= phyPktValid && phyBad;
      if (applyCfg && phyPktData[`LPOC_PHY_T_BIT])
        phyGapCount <= phyPktData[`LPOC_PHY_GAP_HI:`LPOC_PHY_GAP_LO];
      if (applyCfg)
        rootHold <= phyPktData[`LPOC_PHY_R_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gen_q <= 8'h0;
      busResetPktStrobe <= 1'b0;
      remoteReplyTx <= 1'b0;
      remoteConfirmTx <= 1'b0;
      selfIdTx <= 1'b0;
      linkOnSeen_q <= 1'b0;
      linkTrafficEnable <= 1'b0;
      selfIdHeader <= '0;
    end
    else
    begin
      if (busResetDetected)
        gen_q <= gen_q + 8'h1;
      busResetPktStrobe <= busResetDetected &&
        pktCtl_q[`LPOC_RESET_MARKER_BIT];
      remoteReplyTx <= remoteAccessRx && pktCtl_q[`LPOC_REMOTE_BIT];
      remoteConfirmTx <= remoteCommandRx && pktCtl_q[`LPOC_REMOTE_BIT];
      selfIdTx <= pingRx && pktCtl_q[`LPOC_PING_BIT];
      // A link-on arriving with a bus reset is kept
      if (linkOnPktRx)
        linkOnSeen_q <= 1'b1;
      else if (busResetDetected)
        linkOnSeen_q <= 1'b0;
      linkTrafficEnable <= gateOpen;
      if (selfIdDone)
      begin
        selfIdHeader.generation <= gen_q;
        selfIdHeader.timeStamp <= {secIdx_q[2:0], cycIdx_q};
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_READ_GATED: assert property (
    memReq.rd && !debugModeEnable |=> memRdValid && memRdData == 32'h0)
    else $error("debug read answered while debug mode off");
  AST_SET_CLEAR: assert property (
    setHit && wrBits[`LPOC_CONCAT_BIT] && !clrHit
    |=> pktCtl_q[`LPOC_CONCAT_BIT] ##1 concatEnable)
    else $error("set write did not reach concatenate output");
  AST_UNDEF_ZERO: assert property (
    (pktCtl_q & ~`LPOC_PKTCTL_MASK) == 32'h0)
    else $error("undefined option bit became set");
  AST_RESET_MARKER: assert property (
    busResetDetected |=> busResetPktStrobe ==
      $past(pktCtl_q[`LPOC_RESET_MARKER_BIT]))
    else $error("bus reset marker strobe wrong");
  AST_GEN_COUNT: assert property (
    busResetDetected |=> gen_q == $past(gen_q) + 8'h1)
    else $error("generation did not count bus reset");
  AST_PING: assert property (
    selfIdTx |-> $past(pingRx) && $past(pktCtl_q[`LPOC_PING_BIT]))
    else $error("self-ID transmit without enabled ping");
  AST_REMOTE: assert property (
    remoteAccessRx && pktCtl_q[`LPOC_REMOTE_BIT] |=> remoteReplyTx)
    else $error("remote access not answered");
  AST_INVERSE: assert property (
    phyPktValid && pktCtl_q[`LPOC_PHY_VERIFY_BIT] &&
    phyPktInverse != ~phyPktData |=> phyPktError && !phyPktAccept)
    else $error("bad PHY inverse quadlet not flagged");
  AST_LINK_GATE: assert property (
    linkTrafficEnable |-> $past(hostLinkOn) &&
      (!$past(pktCtl_q[`LPOC_LINKON_GATE_BIT]) || $past(linkOnSeen_q)))
    else $error("link traffic enabled without permission");
  AST_STAMP: assert property (
    selfIdDone |=> selfIdHeader.timeStamp ==
      {$past(secIdx_q[2:0]), $past(cycIdx_q)})
    else $error("self-ID timestamp wrong");
  AST_EXT_TICK: assert property (
    useExt && !extEdge |=> cycIdx_q == $past(cycIdx_q))
    else $error("cycle counted without external tick");
  AST_GAP: assert property (
    phyPktValid && !pktCtl_q[`LPOC_PHY_APPLY_BIT] |=> $stable(phyGapCount))
    else $error("gap count changed while apply is off");
endmodule
`default_nettype wire

// file: lpoc_packet_options_tb.sv
`include "lpoc_defs.svh"
`default_nettype none
module lpoc_packet_options_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpoc_pkg::*;
  logic clk, rst_n, dbg, tickSrc, hostLinkOn;
  lpoc_memreq_t req;
  logic [31:0] rdData, pd, pi;
  logic [19:0] ctr, c0;
  logic [31:0] expVal;
  logic [5:0] gap;
  logic [7:0] ev;
  logic rdValid, phyAcc, phyErr, rootHold, brStrobe, concat;
  logic reply, confirm, sidTx, traffic;
  lpoc_selfid_hdr_t hdr;
  int fail_count, n_tests;
  lpoc_far_node far (.clk(clk), .ev(ev), .pktData(pd), .pktInv(pi));
  lpoc_packet_options #(.TICK_CYCLES(8)) dut (
    .clk(clk), .rst_n(rst_n), .memReq(req), .memRdData(rdData),
    .memRdValid(rdValid), .debugModeEnable(dbg),
    .cycleTickSource(tickSrc), .external8kInput(ev[6]),
    .cycleTimeCounter(ctr), .phyPktValid(ev[7]), .phyPktData(pd),
    .phyPktInverse(pi), .phyPktAccept(phyAcc), .phyPktError(phyErr),
    .phyGapCount(gap), .rootHold(rootHold), .busResetDetected(ev[3]),
    .busResetPktStrobe(brStrobe), .concatEnable(concat),
    .remoteAccessRx(ev[1]), .remoteCommandRx(ev[2]),
    .remoteReplyTx(reply), .remoteConfirmTx(confirm), .pingRx(ev[0]),
    .selfIdTx(sidTx), .hostLinkOn(hostLinkOn), .linkOnPktRx(ev[4]),
    .linkTrafficEnable(traffic), .selfIdDone(ev[5]),
    .selfIdHeader(hdr)
  );
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge clk);
    #1 req.wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    #1 req.addr = a;
    req.rd = 1'b1;
    @(posedge clk);
    #1 req.rd = 1'b0;
    check("memRdValid", 32'h1, {31'h0, rdValid});
    check("memRdData", e, rdData);
  endtask
  function automatic logic evOut(input int k);
    case (k)
      0: return sidTx;
      1: return reply;
      2: return confirm;
      default: return brStrobe;
    endcase
  endfunction
  task automatic evt(input int k, input logic e);
    far.pulse(k);
    check("eventOut", {31'h0, e}, {31'h0, evOut(k)});
  endtask
  task automatic phyChk(input logic a, input logic er, input logic [5:0] g);
    check("phyPktAccept", {31'h0, a}, {31'h0, phyAcc});
    check("phyPktError", {31'h0, er}, {31'h0, phyErr});
    @(posedge clk);
    #1 check("phyGapCount", {26'h0, g}, {26'h0, gap});
  endtask
  initial
  begin
    fail_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    dbg = 1'b1;
    tickSrc = 1'b0;
    hostLinkOn = 1'b0;
    req = '0;
    req.byteEn = 4'hF;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(12'h800, `LPOC_PKTCTL_RESET);
    check("phyGapCount", 32'h3F, {26'h0, gap});
    check("concatEnable", 32'h0, {31'h0, concat});
    rd(12'h880, 32'h0);
    rd(12'h700, 32'h0);
    dbg = 1'b0;
    rd(12'h800, 32'h0);
    wr(12'h804, 32'hFFFFFFFF);
    dbg = 1'b1;
    rd(12'h800, 32'h114);
    $display("test reset and access done");
    for (int k = 0; k < 4; k++)
      evt(k, 1'b1);
    wr(12'h804, 32'h114);
    rd(12'h800, 32'h0);
    for (int k = 0; k < 4; k++)
      evt(k, 1'b0);
    req.byteEn = 4'h2;
    wr(12'h800, 32'hFFFFFFFF);
    req.byteEn = 4'hF;
    rd(12'h800, 32'h300);
    $display("test auto answers done");
    wr(12'h800, 32'hFFFFFFFF);
    rd(12'h800, `LPOC_PKTCTL_MASK);
    check("concatEnable", 32'h1, {31'h0, concat});
    far.phy(32'h00D5_0000, 1'b0);
    phyChk(1'b1, 1'b0, 6'h15);
    check("rootHold", 32'h1, {31'h0, rootHold});
    far.phy(32'h004A_0000, 1'b1);
    phyChk(1'b0, 1'b1, 6'h15);
    wr(12'h804, 32'h201);
    far.phy(32'h004A_0000, 1'b1);
    phyChk(1'b1, 1'b0, 6'h15);
    $display("test phy packets done");
    hostLinkOn = 1'b1;
    repeat (2) @(posedge clk);
    #1 check("linkTrafficEnable", 32'h0, {31'h0, traffic});
    far.pulse(4);
    @(posedge clk);
    #1 check("linkTrafficEnable", 32'h1, {31'h0, traffic});
    wr(12'h804, 32'h2);
    far.pulse(3);
    repeat (2) @(posedge clk);
    #1 check("linkTrafficEnable", 32'h1, {31'h0, traffic});
    far.pulse(5);
    check("generation", 32'h3, {24'h0, hdr.generation});
    check("timeStamp", {16'h0, ctr[15:0]}, {16'h0, hdr.timeStamp});
    $display("test link gating done");
    // Internal tick: any 16 clocks hold exactly two ticks of 8
    c0 = ctr;
    repeat (16) @(posedge clk);
    #1 expVal = {19'h0, c0[12:0]} + 32'h2;
    check("cycleIndex", expVal, {19'h0, ctr[12:0]});
    tickSrc = 1'b1;
    repeat (2) @(posedge clk);
    #1 c0 = ctr;
    repeat (3) far.pulse(6);
    repeat (4) @(posedge clk);
    #1 expVal = {19'h0, c0[12:0]} + 32'h3;
    check("cycleIndex", expVal, {19'h0, ctr[12:0]});
    $display("test external tick done");
    conclude();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire

// file: lpoc_pkg.sv
`default_nettype none
package lpoc_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
    logic [3:0] byteEn;
  } lpoc_memreq_t;
  typedef struct packed {
    logic [7:0] generation;
    logic [15:0] timeStamp;
  } lpoc_selfid_hdr_t;
endpackage
`default_nettype wire
